// *** include/tccs_map.vh ***
// Register addresses, field layout, reset values and divider taps for the timers
`ifndef TCCS_MAP_VH
`define TCCS_MAP_VH

// Register byte addresses
`define TCCS_ADDR_SEL0    16'hff6a
`define TCCS_ADDR_SEL1    16'hff8c
// Select field layout and reset value
`define TCCS_SEL_MSB      2
`define TCCS_SEL_RESET    8'h00
`define TCCS_CNT_RESET    8'h00
// Select codes
`define TCCS_CODE_FALL    3'h0
`define TCCS_CODE_RISE    3'h1
`define TCCS_CODE_DIV1    3'h2
`define TCCS_CODE_DIV2    3'h3
`define TCCS_CODE_DIVA    3'h4
`define TCCS_CODE_DIVB    3'h5
`define TCCS_CODE_DIVC    3'h6
`define TCCS_CODE_DIVD    3'h7
// Prescaler tap positions (divide by 2^(tap+1))
`define TCCS_PRE_W        13
`define TCCS_TAP_DIV2     0
`define TCCS_TAP_DIV4     1
`define TCCS_TAP_DIV16    3
`define TCCS_TAP_DIV64    5
`define TCCS_TAP_DIV256   7
`define TCCS_TAP_DIV4096  11
`define TCCS_TAP_DIV8192  12

`endif

// *** src/tccs_timer_clksel.v ***
// Count clock selection and 8-bit counters for two timer/event units
`timescale 1ns/1ps
// How it works
// - Bits 2..0 of each unit's select register choose its count clock.
// - Code 000 counts on external input falling edges, 001 on rising edges.
// - Unit 0 codes 010..111 pick core clock over 1, 2, 4, 64, 256, 8192.
// - Unit 1 codes 010..111 pick core clock over 1, 2, 16, 64, 256, 4096.
// - Reset clears both select registers, choosing the falling edge.
// - Select registers take byte writes and single-bit writes and read back.
// - Each counter increments once per selected count clock edge.
// - A cleared run bit holds the counter at zero; set, it counts.
`include "tccs_map.vh"

module tccs_timer_clksel (
    input  wire        core_clk,   // Peripheral clock, 25 MHz
    input  wire        resetn,     // Asynchronous reset, active low
    input  wire [15:0] addr,       // Register address
    input  wire        wr_en,      // Write strobe
    input  wire        bit_wr,     // Single-bit write when high
    input  wire [2:0]  bit_sel,    // Bit index for single-bit write
    input  wire [7:0]  wdata,      // Write data; bit write uses wdata[0]
    input  wire        rd_en,      // Read strobe
    output reg  [7:0]  rdata,      // Read data
    input  wire        unit0_ext_count_input, // Unit 0 external input
    input  wire        unit1_ext_count_input, // Unit 1 external input
    input  wire        unit0_count_run_bit,   // Unit 0 run control
    input  wire        unit1_count_run_bit,   // Unit 1 run control
    output reg  [7:0]  unit0_counter_value,   // Unit 0 count
    output reg  [7:0]  unit1_counter_value,   // Unit 1 count
    output reg         unit0_count_pulse,     // Unit 0 count enable seen
    output reg         unit1_count_pulse      // Unit 1 count enable seen
);

    reg  [7:0]              unit0_count_clock_select;
    reg  [7:0]              unit1_count_clock_select;
    reg  [`TCCS_PRE_W-1:0]  prescale;
    reg  [`TCCS_PRE_W-1:0]  prescale_q;
    reg  [2:0]              in0_sync;   // [0] is the first flop only
    reg  [2:0]              in1_sync;
    wire [`TCCS_PRE_W-1:0]  tap_rise;
    wire                    en0;
    wire                    en1;
    wire                    fall0;
    wire                    rise0;
    wire                    fall1;
    wire                    rise1;
    wire                    sel0_hit;
    wire                    sel1_hit;

    // Merge a byte or single-bit write into a select register
    // A bit write changes one bit and leaves the others as they were
    function [7:0] tccs_merge;
        input [7:0] old;
        input       is_bit;
        input [2:0] idx;
        input [7:0] data;
        reg   [7:0] tmp;
        begin
            tmp = old;
            if (is_bit) begin
                tmp[idx] = data[0];
            end else begin
                tmp = data;
            end
            tccs_merge = tmp;
        end
    endfunction

    // Pick the count enable for one unit from its select code
    // tap_a and tap_d carry the divider taps that differ between units
    function tccs_pick;
        input [2:0] code;
        input       fall;
        input       rise;
        input       tap_a;
        input       tap_d;
        input [`TCCS_PRE_W-1:0] taps;
        begin
            case (code)
                `TCCS_CODE_FALL: tccs_pick = fall;
                `TCCS_CODE_RISE: tccs_pick = rise;
                `TCCS_CODE_DIV1: tccs_pick = 1'b1;
                `TCCS_CODE_DIV2: tccs_pick = taps[`TCCS_TAP_DIV2];
                `TCCS_CODE_DIVA: tccs_pick = tap_a;
                `TCCS_CODE_DIVB: tccs_pick = taps[`TCCS_TAP_DIV64];
                `TCCS_CODE_DIVC: tccs_pick = taps[`TCCS_TAP_DIV256];
                default:         tccs_pick = tap_d;
            endcase
        end
    endfunction

    // Address decode for the two select registers
    assign sel0_hit = (addr == `TCCS_ADDR_SEL0);
    assign sel1_hit = (addr == `TCCS_ADDR_SEL1);

    // Unit 0 select register: byte and bit writes, cleared on reset
    // Bits 7..3 are stored as written; keeping them zero is up to software
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            unit0_count_clock_select <= `TCCS_SEL_RESET;
        end else if (wr_en && sel0_hit) begin
            unit0_count_clock_select <= tccs_merge(
                unit0_count_clock_select, bit_wr, bit_sel, wdata);
        end
    end

    // Unit 1 select register: same write behaviour as unit 0
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            unit1_count_clock_select <= `TCCS_SEL_RESET;
        end else if (wr_en && sel1_hit) begin
            unit1_count_clock_select <= tccs_merge(
                unit1_count_clock_select, bit_wr, bit_sel, wdata);
        end
    end

    // Read port; unmapped addresses read zero
    // A read in the same cycle as a write returns the old value
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= `TCCS_SEL_RESET;
        end else if (rd_en) begin
            if (sel0_hit) begin
                rdata <= unit0_count_clock_select;
            end else if (sel1_hit) begin
                rdata <= unit1_count_clock_select;
            end else begin
                rdata <= `TCCS_SEL_RESET;
            end
        end
    end

    // Free-running prescaler shared by both units
    // It never stops, so the first divided pulse after a start comes
    // anywhere from one cycle to a full period later
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prescale   <= {`TCCS_PRE_W{1'b0}};
            prescale_q <= {`TCCS_PRE_W{1'b0}};
        end else begin
            prescale   <= prescale + {{(`TCCS_PRE_W-1){1'b0}}, 1'b1};
            prescale_q <= prescale;
        end
    end

    // One-cycle pulse at each rising edge of every divided tap
    assign tap_rise = prescale & ~prescale_q;

    // Unit 0 pin: two synchroniser flops plus one history flop
    // A level held for less than one cycle may be missed
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            in0_sync <= 3'h0;
        end else begin
            in0_sync <= {in0_sync[1:0], unit0_ext_count_input};
        end
    end

    // Unit 1 pin: same chain as unit 0
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            in1_sync <= 3'h0;
        end else begin
            in1_sync <= {in1_sync[1:0], unit1_ext_count_input};
        end
    end

    // Edges seen between the second synchroniser flop and the history flop
    assign fall0 = in0_sync[2] & ~in0_sync[1];
    assign rise0 = in0_sync[1] & ~in0_sync[2];
    assign fall1 = in1_sync[2] & ~in1_sync[1];
    assign rise1 = in1_sync[1] & ~in1_sync[2];

    // Unit 0 count enable from the low select bits
    assign en0 = tccs_pick(
        unit0_count_clock_select[`TCCS_SEL_MSB:0],
        fall0,
        rise0,
        tap_rise[`TCCS_TAP_DIV4],
        tap_rise[`TCCS_TAP_DIV8192],
        tap_rise);

    // Unit 1 count enable; its taps differ at codes 100 and 111
    assign en1 = tccs_pick(
        unit1_count_clock_select[`TCCS_SEL_MSB:0],
        fall1,
        rise1,
        tap_rise[`TCCS_TAP_DIV16],
        tap_rise[`TCCS_TAP_DIV4096],
        tap_rise);

    // Unit 0 counter: cleared while stopped, advances on each enable
    // The pulse output marks the cycle in which the count moved
    // The count wraps from ff to 00 with no flag of its own
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            unit0_counter_value <= `TCCS_CNT_RESET;
            unit0_count_pulse   <= 1'b0;
        end else begin
            unit0_count_pulse <= unit0_count_run_bit & en0;
            if (!unit0_count_run_bit) begin
                unit0_counter_value <= `TCCS_CNT_RESET;
            end else if (en0) begin
                unit0_counter_value <= unit0_counter_value + 8'h01;
            end
        end
    end

    // Unit 1 counter: same behaviour as unit 0
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            unit1_counter_value <= `TCCS_CNT_RESET;
            unit1_count_pulse   <= 1'b0;
        end else begin
            unit1_count_pulse <= unit1_count_run_bit & en1;
            if (!unit1_count_run_bit) begin
                unit1_counter_value <= `TCCS_CNT_RESET;
            end else if (en1) begin
                unit1_counter_value <= unit1_counter_value + 8'h01;
            end
        end
    end

endmodule

// *** sim/tccs_pin_src.sv ***
// Pulse source model for the external count input pin
`timescale 1ns/1ps
module tccs_pin_src (
    input  wire       core_clk, // Clock
    input  wire       resetn,   // Reset, active low
    input  wire       go,       // Burst enable
    output reg        pin,      // Pin level
    output reg  [7:0] rises,    // Rising edges made
    output reg  [7:0] falls     // Falling edges made
);
    reg [1:0] ph;
    // Toggle every third cycle so each level outlasts the synchroniser
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            {pin, rises, falls, ph} <= 19'h00000;
        end else if (go) begin
            ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
            if (ph == 2'h2) begin
                pin <= ~pin;
                rises <= rises + {7'h00, ~pin};
                falls <= falls + {7'h00, pin};
            end
        end
    end
endmodule

// *** sim/tccs_props.sv ***
// Port properties of the timer count clock selection block
`timescale 1ns/1ps
`include "tccs_map.vh"
module tccs_props (
    input wire        core_clk,            // Clock
    input wire        resetn,              // Reset, active low
    input wire [15:0] addr,                // Address
    input wire        rd_en,               // Read strobe
    input wire [7:0]  rdata,               // Read data
    input wire        unit0_count_run_bit, // Unit 0 run
    input wire        unit1_count_run_bit, // Unit 1 run
    input wire [7:0]  unit0_counter_value, // Unit 0 count
    input wire [7:0]  unit1_counter_value, // Unit 1 count
    input wire        unit0_count_pulse,   // Unit 0 pulse
    input wire        unit1_count_pulse    // Unit 1 pulse
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_clr0; !unit0_count_run_bit |=> unit0_counter_value == 8'h00;
    endproperty
    a_clr0: assert property (p_clr0) else $error("u0 not cleared");
    property p_clr1; !unit1_count_run_bit [*2] |-> unit1_counter_value
        == 8'h00 && !unit1_count_pulse; endproperty
    a_clr1: assert property (p_clr1) else $error("u1 not cleared");
    property p_inc0; unit0_count_pulse |->
        unit0_counter_value == $past(unit0_counter_value) + 8'h01; endproperty
    a_inc0: assert property (p_inc0) else $error("u0 bad step");
    property p_inc1; unit1_count_pulse |->
        unit1_counter_value == $past(unit1_counter_value) + 8'h01; endproperty
    a_inc1: assert property (p_inc1) else $error("u1 bad step");
    property p_hold0; !unit0_count_pulse && $past(unit0_count_run_bit)
        |-> $stable(unit0_counter_value); endproperty
    a_hold0: assert property (p_hold0) else $error("u0 moved");
    property p_hold1; !unit1_count_pulse && $past(unit1_count_run_bit)
        |-> $stable(unit1_counter_value); endproperty
    a_hold1: assert property (p_hold1) else $error("u1 moved");
    property p_unmap; rd_en && addr != `TCCS_ADDR_SEL0 &&
        addr != `TCCS_ADDR_SEL1 |=> rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_keep; !rd_en |=> $stable(rdata); endproperty
    a_keep: assert property (p_keep) else $error("rdata moved");
    c_p0: cover property (unit0_count_pulse ##1 unit0_count_pulse);
    c_p1: cover property (unit1_count_pulse);
    c_rd: cover property (rd_en ##1 rdata != 8'h00);
endmodule
bind tccs_timer_clksel tccs_props i_tccs_props (.*);

// *** sim/testbench.sv ***
// Self-checking bench for the timer count clock selection block
`timescale 1ns/1ps
`include "tccs_map.vh"
module testbench;
    reg         core_clk = 1'b0, resetn = 1'b0, wr_en = 1'b0, go = 1'b0;
    reg         bit_wr = 1'b0, rd_en = 1'b0;
    reg  [15:0] addr = 16'h0000;
    reg  [2:0]  bit_sel = 3'h0;
    reg  [7:0]  wdata = 8'h00;
    reg  [1:0]  run = 2'h0;
    wire [7:0]  rdata, cnt0, cnt1, rises, falls;
    wire [1:0]  pls;
    wire        pin;
    integer     err_count = 0, tests_run = 0, cyc = 0, n, c;
    integer     dv0 [0:5] = '{1, 2, 4, 64, 256, 8192};
    integer     dv1 [0:5] = '{1, 2, 16, 64, 256, 4096};
    tccs_timer_clksel i_tccs_timer_clksel (.core_clk(core_clk),
        .resetn(resetn), .addr(addr), .wr_en(wr_en), .bit_wr(bit_wr),
        .bit_sel(bit_sel), .wdata(wdata), .rd_en(rd_en), .rdata(rdata),
        .unit0_ext_count_input(pin), .unit1_ext_count_input(pin),
        .unit0_count_run_bit(run[0]), .unit1_count_run_bit(run[1]),
        .unit0_counter_value(cnt0), .unit1_counter_value(cnt1),
        .unit0_count_pulse(pls[0]), .unit1_count_pulse(pls[1]));
    tccs_pin_src i_tccs_pin_src (.core_clk(core_clk), .resetn(resetn),
        .go(go), .pin(pin), .rises(rises), .falls(falls));
    // Clock and hang guard
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count = err_count + 1;
            give_verdict;
        end
    end
    task give_verdict;
        begin
            $display("errors %0d checks %0d", err_count, tests_run);
            if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [15:0] seen, exp, input [63:0] what);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("[ERR] %0s exp %h seen %h", what, exp, seen);
            end
        end
    endtask
    // Byte or single-bit write, strobe held for one cycle, with no read back
    task wr(input [15:0] a, input [7:0] d, input b, input [2:0] i);
        begin
            @(negedge core_clk);
            {addr, wdata, bit_wr, bit_sel, wr_en} = {a, d, b, i, 1'b1};
            @(negedge core_clk);
            wr_en = 1'b0;
        end
    endtask
    task rd(input [15:0] a, input [7:0] e);
        begin
            @(negedge core_clk);
            {addr, rd_en} = {a, 1'b1};
            @(negedge core_clk);
            rd_en = 1'b0;
            @(negedge core_clk);
            chk(rdata, e, "rdata");
        end
    endtask
    // Measure the spacing of two count pulses, then stop the timer and check it clears
    task per(input u, input [2:0] cd, input [15:0] d);
        begin
            wr(u ? `TCCS_ADDR_SEL1 : `TCCS_ADDR_SEL0,
                {5'h00, cd}, 1'b0, 3'h0);
            run[u] = 1'b1;
            n = 0;
            while (pls[u] !== 1'b1) @(negedge core_clk);
            @(negedge core_clk);
            while (pls[u] !== 1'b1) begin
                n = n + 1;
                @(negedge core_clk);
            end
            chk(n + 1, d, "period");
            chk(u ? cnt1 : cnt0, 16'h0002, "count");
            run[u] = 1'b0;
            @(negedge core_clk);
            chk(u ? cnt1 : cnt0, 16'h0000, "clear");
        end
    endtask
    // Pin edges: sw low, unit 0 counts falls and unit 1 rises; sw high swaps
    task edges(input sw);
        reg [7:0] r0, f0, e0, e1;
        begin
            for (c = 0; c < 3; c = c + 1)
                wr(`TCCS_ADDR_SEL0, {7'h00, sw & (c == 0)}, 1'b1, c);
            rd(`TCCS_ADDR_SEL0, {7'h00, sw});
            wr(`TCCS_ADDR_SEL1, {7'h00, ~sw}, 1'b0, 3'h0);
            {r0, f0} = {rises, falls};
            run = 2'h3;
            go = 1'b1;
            repeat (200) @(negedge core_clk);
            go = 1'b0;
            repeat (6) @(negedge core_clk);
            e0 = sw ? rises - r0 : falls - f0;
            e1 = sw ? falls - f0 : rises - r0;
            chk(cnt0, e0, "edges0");
            chk(cnt1, e1, "edges1");
            run = 2'h0;
        end
    endtask
    // Reset with both timers stopped clears select registers that hold written values
    task rst_mid;
        begin
            wr(`TCCS_ADDR_SEL1, 8'h06, 1'b0, 3'h0);
            @(negedge core_clk);
            resetn = 1'b0;
            repeat (2) @(negedge core_clk);
            resetn = 1'b1;
            rd(`TCCS_ADDR_SEL0, 8'h00);
            rd(`TCCS_ADDR_SEL1, 8'h00);
        end
    endtask
    initial begin
        repeat (3) @(negedge core_clk);
        resetn = 1'b1;
        rd(`TCCS_ADDR_SEL0, 8'h00);
        rd(`TCCS_ADDR_SEL1, 8'h00);
        wr(`TCCS_ADDR_SEL0, 8'h05, 1'b0, 3'h0);
        wr(`TCCS_ADDR_SEL0, 8'h01, 1'b1, 3'h1);
        rd(`TCCS_ADDR_SEL0, 8'h07);
        rd(16'hff6b, 8'h00);
        // Supply is taken as nominal, so code 010 is a legal choice here
        for (c = 2; c < 8; c = c + 1) begin
            per(1'b0, c, dv0[c - 2]);
            per(1'b1, c, dv1[c - 2]);
        end
        edges(1'b0);
        edges(1'b1);
        rst_mid;
        give_verdict;
    end
endmodule
